// *** gpp_ctrl.sv ***
// Twelve-pin controller with time-capture and time-event pins.
// Assumes asynchronous pin inputs, an external precision clock value
// and compare pulse, and an outside resolver for the pin wires.
//
// Decided for this implementation: the register offsets and the plain strobed port.
module gpp_ctrl #(
	parameter int PIN_FILT_CYC = gpp_pkg::FILT_CYC
) (
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic [gpp_pkg::ADDR_W-1:0] ADDR,
	input wire logic [gpp_pkg::DATA_W-1:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [gpp_pkg::DATA_W-1:0] RDATA,
	input wire logic [gpp_pkg::NUM_PINS-1:0] PIN_IN,
	output logic [gpp_pkg::NUM_PINS-1:0] PIN_OUT,
	output logic [gpp_pkg::NUM_PINS-1:0] PIN_OE,
	input wire logic [gpp_pkg::TIME_W-1:0] TIME_NOW,
	input wire logic TIME_TARGET_HIT,
	input wire logic [2*gpp_pkg::NUM_PORTS-1:0] TS_EVT,
	input wire logic [gpp_pkg::NUM_LED-1:0] LED_STRAPS,
	input wire logic [gpp_pkg::NUM_LED-1:0] LED_DRIVE_N,
	output logic TIME_EVENT_SUMMARY,
	output logic PIN_IRQ_SUMMARY
);
	import gpp_pkg::*;

	// ********************************************************
	// Helpers
	// ********************************************************
	function automatic logic hit(input logic [ADDR_W-1:0] a,
		input logic [ADDR_W-1:0] off);
		return a == off;
	endfunction

	// Set beats clear so an event in the clearing cycle survives.
	function automatic logic [DATA_W-1:0] sticky(
		input logic [DATA_W-1:0] old, input logic [DATA_W-1:0] set,
		input logic [DATA_W-1:0] clr);
		return set | (old & ~clr);
	endfunction

	// ********************************************************
	// Reset release and pin synchronisers
	// ********************************************************
	logic rst_q1, rst_n;
	logic [NUM_PINS-1:0] pin_s1, pin_s;

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			rst_q1 <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_q1 <= 1'b1;
			rst_n <= rst_q1;
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1 <= '1;
			pin_s <= '1;
		end else if (CE) begin
			pin_s1 <= PIN_IN;
			pin_s <= pin_s1;
		end
	end

	// ********************************************************
	// Configuration registers
	// ********************************************************
	logic [NUM_PINS-1:0] val_q, dir_q, buf_q, pol_q, pin_en;
	logic [1:0] tmoe_q, epol_q, clren_q;
	logic [3:0] emode_q;
	logic [NUM_LED-1:0] led_en;
	logic strap_done;
	logic [NUM_TSRC-1:0] time_en;
	logic wr_ok;

	assign wr_ok = CE && WR;

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			val_q <= '0;
			dir_q <= '0;
			buf_q <= '0;
			pol_q <= '0;
			pin_en <= '0;
			tmoe_q <= '0;
			epol_q <= '0;
			clren_q <= '0;
			emode_q <= '0;
			time_en <= '0;
		end else if (wr_ok) begin
			if (hit(ADDR, OFF_DATA_DIR)) begin
				val_q <= WDATA[NUM_PINS-1:0];
				dir_q <= WDATA[F_DIR_LSB +: NUM_PINS];
			end
			if (hit(ADDR, OFF_BUF_CFG)) begin
				buf_q <= WDATA[NUM_PINS-1:0];
				tmoe_q <= WDATA[F_TMOE_LSB +: 2];
				epol_q <= WDATA[F_EPOL_LSB +: 2];
				clren_q <= WDATA[F_CLREN_LSB +: 2];
			end
			if (hit(ADDR, OFF_IRQ_POL)) begin
				pol_q <= WDATA[NUM_PINS-1:0];
			end
			if (hit(ADDR, OFF_PIN_IRQ)) begin
				pin_en <= WDATA[F_EN_LSB +: NUM_PINS];
			end
			if (hit(ADDR, OFF_TIME_IRQ)) begin
				time_en <= WDATA[F_EN_LSB +: NUM_TSRC];
			end
			if (hit(ADDR, OFF_EVT_MODE)) begin
				emode_q <= WDATA[3:0];
			end
		end
	end

	// Straps are caught once, on the first enabled edge after release.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			led_en <= '0;
			strap_done <= 1'b0;
		end else if (CE) begin
			if (!strap_done) begin
				led_en <= LED_STRAPS;
				strap_done <= 1'b1;
			end else if (WR && hit(ADDR, OFF_LED_CFG)) begin
				led_en <= WDATA[NUM_LED-1:0];
			end
		end
	end

	// ********************************************************
	// Capture pins
	// ********************************************************
	logic [NUM_PINS-1:0] dir_eff;
	logic [1:0] cap_edge;
	logic [TIME_W-1:0] cap_q [2];

	assign dir_eff = dir_q | {2'b00, tmoe_q, 8'h00};

	for (genvar g = 0; g < 2; g++) begin : g_qual
		logic raw_edge;
		gpp_edge_qual #(.MIN_CYC(PIN_FILT_CYC)) u_qual (
			.clk(CLK),
			.rst_n(rst_n),
			.ce(CE),
			.level(pin_s[TIME_PIN_LSB+g]),
			.active_high(pol_q[TIME_PIN_LSB+g]),
			.edge_pulse(raw_edge)
		);
		assign cap_edge[g] = raw_edge && !dir_eff[TIME_PIN_LSB+g];

		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				cap_q[g] <= '0;
			end else if (cap_edge[g]) begin
				cap_q[g] <= TIME_NOW;
			end
		end
	end

	// ********************************************************
	// Interrupt flags
	// ********************************************************
	logic [NUM_PINS-1:0] pin_flag, pin_set, pin_clr;
	logic [NUM_TSRC-1:0] time_flag, time_set, time_clr;
	logic timer_pin_clr;

	assign pin_set = ~(pin_s ^ pol_q)
		| {2'b00, cap_edge, 8'h00};
	assign pin_clr = (wr_ok && hit(ADDR, OFF_PIN_IRQ)) ?
		WDATA[NUM_PINS-1:0] : '0;
	assign timer_pin_clr = |(cap_edge & clren_q);
	assign time_set = {TIME_TARGET_HIT, cap_edge, TS_EVT};
	assign time_clr = ((wr_ok && hit(ADDR, OFF_TIME_IRQ)) ?
		WDATA[NUM_TSRC-1:0] : '0) | {timer_pin_clr, 8'h00};

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			pin_flag <= '0;
			time_flag <= '0;
		end else if (CE) begin
			pin_flag <= NUM_PINS'(sticky(DATA_W'(pin_flag),
				DATA_W'(pin_set), DATA_W'(pin_clr)));
			time_flag <= NUM_TSRC'(sticky(DATA_W'(time_flag),
				DATA_W'(time_set), DATA_W'(time_clr)));
		end
	end

	// Summaries are registered so the system side sees clean levels.
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			TIME_EVENT_SUMMARY <= 1'b0;
			PIN_IRQ_SUMMARY <= 1'b0;
		end else if (CE) begin
			TIME_EVENT_SUMMARY <= |(time_flag & time_en);
			PIN_IRQ_SUMMARY <= |(pin_flag & pin_en);
		end
	end

	// ********************************************************
	// Compare-event outputs
	// ********************************************************
	logic [CNT_W-1:0] pcnt [2];
	logic [1:0] tog, evt_act;

	for (genvar g = 0; g < 2; g++) begin : g_evt
		logic [1:0] mode;
		assign mode = emode_q[2*g +: 2];

		always_ff @(posedge CLK or negedge rst_n) begin
			if (!rst_n) begin
				pcnt[g] <= '0;
				tog[g] <= 1'b0;
			end else if (CE) begin
				if (TIME_TARGET_HIT && mode == EM_PULSE) begin
					pcnt[g] <= CNT_W'(PULSE_CYC);
				end else if (pcnt[g] != '0) begin
					pcnt[g] <= pcnt[g] - 1'b1;
				end
				if (TIME_TARGET_HIT && mode == EM_TOGGLE) begin
					tog[g] <= ~tog[g];
				end
			end
		end

		always_comb begin
			unique case (mode)
				EM_PULSE: evt_act[g] = (pcnt[g] != '0);
				EM_TOGGLE: evt_act[g] = tog[g];
				EM_FOLLOW: evt_act[g] = time_flag[TF_TIMER];
				EM_OFF: evt_act[g] = 1'b0;
			endcase
		end
	end

	// ********************************************************
	// Pin drivers
	// ********************************************************
	logic [NUM_PINS-1:0] drv, led_w, led_on, next_out, next_oe;

	// Low polarity inverts the active level of the event output.
	assign drv = (val_q & ~{2'b00, tmoe_q, 8'h00})
		| {2'b00, tmoe_q & ~(evt_act ^ epol_q), 8'h00};
	assign led_w = {4'h0, led_en};
	assign led_on = {4'h0, ~LED_DRIVE_N};

	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (led_w[i]) begin
				next_out[i] = 1'b0;
				next_oe[i] = led_on[i];
			end else if (dir_eff[i] && buf_q[i]) begin
				next_out[i] = 1'b0;
				next_oe[i] = ~drv[i];
			end else if (dir_eff[i]) begin
				next_out[i] = drv[i];
				next_oe[i] = 1'b1;
			end else begin
				next_out[i] = 1'b0;
				next_oe[i] = 1'b0;
			end
		end
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			PIN_OUT <= '0;
			PIN_OE <= '0;
		end else if (CE) begin
			PIN_OUT <= next_out;
			PIN_OE <= next_oe;
		end
	end

	// ********************************************************
	// Register read port
	// ********************************************************
	logic [DATA_W-1:0] next_rdata;
	logic [NUM_PINS-1:0] rd_val;

	assign rd_val = (val_q & dir_eff) | (pin_s & ~dir_eff);

	always_comb begin
		next_rdata = '0;
		case (ADDR)
			OFF_DATA_DIR: begin
				next_rdata[NUM_PINS-1:0] = rd_val;
				next_rdata[F_DIR_LSB +: NUM_PINS] = dir_q;
			end
			OFF_BUF_CFG: begin
				next_rdata[NUM_PINS-1:0] = buf_q;
				next_rdata[F_TMOE_LSB +: 2] = tmoe_q;
				next_rdata[F_EPOL_LSB +: 2] = epol_q;
				next_rdata[F_CLREN_LSB +: 2] = clren_q;
			end
			OFF_IRQ_POL: next_rdata[NUM_PINS-1:0] = pol_q;
			OFF_PIN_IRQ: begin
				next_rdata[NUM_PINS-1:0] = pin_flag;
				next_rdata[F_EN_LSB +: NUM_PINS] = pin_en;
			end
			OFF_TIME_IRQ: begin
				next_rdata[NUM_TSRC-1:0] = time_flag;
				next_rdata[F_EN_LSB +: NUM_TSRC] = time_en;
			end
			OFF_EVT_MODE: next_rdata[3:0] = emode_q;
			OFF_LED_CFG: next_rdata[NUM_LED-1:0] = led_en;
			OFF_SYS_STAT: begin
				next_rdata[SYS_PIN_BIT] = PIN_IRQ_SUMMARY;
				next_rdata[SYS_TIME_BIT] = TIME_EVENT_SUMMARY;
			end
			OFF_CAP8_HI: next_rdata = cap_q[0][TIME_W-1:HALF_W];
			OFF_CAP8_LO: next_rdata = cap_q[0][HALF_W-1:0];
			OFF_CAP9_HI: next_rdata = cap_q[1][TIME_W-1:HALF_W];
			OFF_CAP9_LO: next_rdata = cap_q[1][HALF_W-1:0];
			default: next_rdata = '0;
		endcase
	end

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			RDATA <= '0;
		end else if (CE) begin
			RDATA <= RD ? next_rdata : '0;
		end
	end

	// ********************************************************
	// Checks
	// ********************************************************
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!rst_n);

	a_time_summary: assert property (
		CE && |(time_flag & time_en) |=> TIME_EVENT_SUMMARY)
		else $error("Enabled time flag missing from summary.");
	a_ts_source: assert property (
		CE && TS_EVT[0] |=> time_flag[0])
		else $error("Timestamp event did not set its flag.");
	a_timer_clear: assert property (
		CE && cap_edge[0] && clren_q[0] && !TIME_TARGET_HIT
		|=> !time_flag[TF_TIMER])
		else $error("Pin edge did not clear target flag.");
	a_reset_state: assert property (
		$rose(rst_n) |-> dir_q == '0 && pin_en == '0 && pol_q == '0)
		else $error("Configuration not cleared by reset.");
	a_led_strap: assert property (
		$rose(strap_done) |-> led_en == $past(LED_STRAPS))
		else $error("LED enables differ from straps.");
	a_od_drive: assert property (
		CE && dir_q[11] && buf_q[11]
		|=> !PIN_OUT[11] && PIN_OE[11] == !$past(val_q[11]))
		else $error("Open-drain pin driven wrongly.");
	a_pp_drive: assert property (
		CE && dir_q[11] && !buf_q[11]
		|=> PIN_OE[11] && PIN_OUT[11] == $past(val_q[11]))
		else $error("Push-pull pin driven wrongly.");
	a_cap_copy: assert property (
		cap_edge[0] |=> cap_q[0] == $past(TIME_NOW))
		else $error("Capture register missed the clock.");
	a_cap_flags: assert property (
		cap_edge[1] |=> pin_flag[9] && time_flag[TF_CAP9])
		else $error("Capture did not set both flags.");
	a_pulse_start: assert property (
		CE && TIME_TARGET_HIT && emode_q[1:0] == EM_PULSE
		|=> evt_act[0])
		else $error("Event pulse did not start.");
	a_level_irq: assert property (
		CE && pin_s[11] == pol_q[11] |=> pin_flag[11])
		else $error("Level match did not set pin flag.");
	a_pin_summary: assert property (
		CE && |(pin_flag & pin_en) |=> PIN_IRQ_SUMMARY)
		else $error("Enabled pin flag missing from summary.");
	a_flag_sticky: assert property (
		CE && pin_flag[11] && !pin_clr[11] |=> pin_flag[11])
		else $error("Pin flag dropped without a clear.");

	c_capture: cover property (cap_edge[0] ##1 cap_edge[1]);
	c_toggle: cover property (tog[1] ##1 !tog[1]);
	c_od_low: cover property (PIN_OE[11] && !PIN_OUT[11]);

endmodule // gpp_ctrl

// *** gpp_pkg.sv ***
// Constants, register map and field layout of the pin controller.
// Assumes a 20 MHz system clock and a word-aligned register port.
package gpp_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int NUM_PINS = 12;
	localparam int NUM_LED = 8;
	localparam int NUM_PORTS = 3;
	localparam int NUM_TSRC = 2 * NUM_PORTS + 3;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int TIME_W = 64;
	localparam int HALF_W = 32;
	localparam int CNT_W = 4;
	localparam int TIME_PIN_LSB = 8;

	// ********************************************************
	// Register offsets
	// ********************************************************
	localparam logic [ADDR_W-1:0] OFF_DATA_DIR = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_BUF_CFG = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_IRQ_POL = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PIN_IRQ = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_TIME_IRQ = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_EVT_MODE = 8'h14;
	localparam logic [ADDR_W-1:0] OFF_LED_CFG = 8'h18;
	localparam logic [ADDR_W-1:0] OFF_SYS_STAT = 8'h1C;
	localparam logic [ADDR_W-1:0] OFF_CAP8_HI = 8'h20;
	localparam logic [ADDR_W-1:0] OFF_CAP8_LO = 8'h24;
	localparam logic [ADDR_W-1:0] OFF_CAP9_HI = 8'h28;
	localparam logic [ADDR_W-1:0] OFF_CAP9_LO = 8'h2C;

	// ********************************************************
	// Field positions
	// ********************************************************
	localparam int F_DIR_LSB = 16;
	localparam int F_EN_LSB = 16;
	localparam int F_TMOE_LSB = 12;
	localparam int F_EPOL_LSB = 14;
	localparam int F_CLREN_LSB = 16;
	localparam int SYS_PIN_BIT = 12;
	localparam int SYS_TIME_BIT = 13;
	localparam int TF_CAP8 = 2 * NUM_PORTS;
	localparam int TF_CAP9 = 2 * NUM_PORTS + 1;
	localparam int TF_TIMER = 2 * NUM_PORTS + 2;

	// ********************************************************
	// Event output modes
	// ********************************************************
	localparam logic [1:0] EM_OFF = 2'h0;
	localparam logic [1:0] EM_PULSE = 2'h1;
	localparam logic [1:0] EM_TOGGLE = 2'h2;
	localparam logic [1:0] EM_FOLLOW = 2'h3;

	// ********************************************************
	// Timing
	// ********************************************************
	localparam int CLK_NS = 50;
	localparam int FILT_NS = 40;
	localparam int FILT_RAW = (FILT_NS + CLK_NS - 1) / CLK_NS;
	localparam int FILT_CYC = (FILT_RAW < 1) ? 1 : FILT_RAW;
	localparam int PULSE_NS = 100;
	localparam int PULSE_RAW = PULSE_NS / CLK_NS;
	localparam int PULSE_CYC = (PULSE_RAW < 1) ? 1 : PULSE_RAW;

endpackage

// *** gpp_edge_qual.sv ***
// Active-edge qualifier for one time-capable pin.
// Assumes its level input is already synchronised to the clock.
module gpp_edge_qual #(
	parameter int MIN_CYC = gpp_pkg::FILT_CYC
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	input wire logic level,
	input wire logic active_high,
	output logic edge_pulse
);
	import gpp_pkg::*;

	logic act;
	logic [CNT_W-1:0] run;

	assign act = (level == active_high);

	// A glitch shorter than the window restarts the run.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			run <= '0;
		end else if (ce) begin
			if (!act) begin
				run <= '0;
			end else if (run <= CNT_W'(MIN_CYC)) begin
				run <= run + 1'b1;
			end
		end
	end

	assign edge_pulse = ce && act && (run == CNT_W'(MIN_CYC));

	// ********************************************************
	// Checks
	// ********************************************************
	a_edge_min: assert property (@(posedge clk) disable iff (!rst_n)
		edge_pulse |-> act && $past(act))
		else $error("Edge accepted without a held active level.");

endmodule // gpp_edge_qual

// *** gpp_board_model.sv ***
// Board side of the twelve pin wires: pull-ups plus an outside driver.
// Assumes the controller's pin outputs and enables as seen at its ports.
module gpp_board_model (
	input wire logic [11:0] pin_out,
	input wire logic [11:0] pin_oe,
	input wire logic [11:0] ext_val,
	input wire logic [11:0] ext_en,
	output logic [11:0] pin_wire
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// Wire resolution
	// ************************************************************
	// Every pin has a pull-up, so a released open-drain pin reads high.
	// The controller wins a clash so that its drive is what is seen.
	always_comb begin
		for (int i = 0; i < 12; i++) begin
			pin_wire[i] = pin_oe[i] ? pin_out[i] :
				(ext_en[i] ? ext_val[i] : 1'b1);
		end
	end
endmodule // gpp_board_model

// *** gpp_ctrl_test.sv ***
// Self-checking bench of the pin controller with a board model.
// Assumes the register map and timing constants of the package.
module gpp_ctrl_test;
	timeunit 1ns;
	timeprecision 1ps;
	import gpp_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_d = 1'b0;
	logic ce = 1'b1;
	logic hit = 1'b0;
	logic [ADDR_W-1:0] addr = '0;
	logic [DATA_W-1:0] wdata = '0;
	logic [DATA_W-1:0] rdata;
	logic [NUM_PINS-1:0] pin_wire, pin_out, pin_oe, f;
	logic [NUM_PINS-1:0] ext_val = 12'hFFF;
	logic [NUM_PINS-1:0] ext_en = '0;
	logic [TIME_W-1:0] tnow = '0;
	logic [5:0] ts = '0;
	logic [7:0] drv_n = 8'hFF;
	logic time_sum, pin_sum, pre8, pre9;
	logic [39:0] note;
	logic [39:0] expq [$];
	logic [31:0] r, p;
	int seed, cnt;
	int cmp_count = 0;
	int n_mismatch = 0;
	gpp_ctrl dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.PIN_IN(pin_wire), .PIN_OUT(pin_out), .PIN_OE(pin_oe),
		.TIME_NOW(tnow), .TIME_TARGET_HIT(hit), .TS_EVT(ts),
		.LED_STRAPS(8'h0F), .LED_DRIVE_N(drv_n),
		.TIME_EVENT_SUMMARY(time_sum), .PIN_IRQ_SUMMARY(pin_sum));
	gpp_board_model board (.pin_out(pin_out), .pin_oe(pin_oe),
		.ext_val(ext_val), .ext_en(ext_en), .pin_wire(pin_wire));
	// ************************************************************
	// Bus tasks and checking
	// ************************************************************
	task automatic check(input string n, input logic [63:0] e,
		input logic [63:0] g);
		cmp_count++;
		if (g !== e) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		expq.push_back({a, e});
		@(posedge clk);
		rd <= 1'b0;
	endtask
	task automatic end_sim;
		$display("Comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Read data stand only in the cycle after the strobe.
	always @(posedge clk)
		rd_d <= rd;
	always @(negedge clk) begin
		if (rd_d) begin
			note = expq.pop_front();
			check($sformatf("reg_%h", note[39:32]), note[31:0], rdata);
		end
	end
	initial forever #25 clk = ~clk;
	initial begin
		repeat (20000) @(posedge clk);
		n_mismatch++;
		end_sim();
	end
	// ************************************************************
	// Scenarios
	// ************************************************************
	initial begin
		seed = 87862;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		repeat (5) @(posedge clk);
		rreg(OFF_LED_CFG, 32'h0000_000F);
		rreg(OFF_IRQ_POL, 32'h0000_0000);
		rreg(OFF_PIN_IRQ, 32'h0000_0000);
		@(posedge clk);
		drv_n <= 8'($random(seed));
		tick(3);
		check("led_oe", {4'h0, ~drv_n[3:0]}, pin_oe[7:0]);
		check("led_out", 64'h0, pin_out[3:0]);
		wreg(OFF_LED_CFG, 32'h0000_0000);
		// The released LED pins need the synchroniser to catch up.
		tick(3);
		rreg(OFF_DATA_DIR, 32'h0000_0FFF);
		wreg(OFF_DATA_DIR, 32'h0FFF_0A5A);
		tick(2);
		check("oe", 64'hFFF, pin_oe);
		check("out", 64'hA5A, pin_out);
		rreg(OFF_DATA_DIR, 32'h0FFF_0A5A);
		wreg(OFF_BUF_CFG, 32'h0000_0FFF);
		tick(2);
		check("od_oe", 64'h5A5, pin_oe);
		check("od_wire", 64'hA5A, pin_wire);
		wreg(OFF_BUF_CFG, 32'h0000_0000);
		wreg(OFF_DATA_DIR, 32'h0000_0000);
		// Level interrupts with random pin levels and polarities.
		r = $random(seed);
		p = $random(seed);
		f = ~(r[11:0] ^ p[11:0]);
		wreg(OFF_IRQ_POL, {20'h0, p[11:0]});
		@(posedge clk);
		ext_en <= 12'hFFF;
		ext_val <= ~p[11:0];
		tick(4);
		wreg(OFF_PIN_IRQ, 32'h0FFF_0FFF);
		rreg(OFF_PIN_IRQ, 32'h0FFF_0000);
		@(posedge clk);
		ext_val <= r[11:0];
		tick(6);
		rreg(OFF_DATA_DIR, {20'h0, r[11:0]});
		rreg(OFF_PIN_IRQ, {16'h0FFF, 4'h0, f});
		rreg(OFF_SYS_STAT, {19'h0, |f, 12'h0});
		check("pin_sum", 64'(|f), pin_sum);
		wreg(OFF_PIN_IRQ, 32'h0000_0000);
		tick(2);
		check("pin_sum_off", 64'h0, pin_sum);
		// Time flags, gating and the summary bit.
		@(posedge clk);
		ext_val <= 12'hCFF;
		wreg(OFF_IRQ_POL, 32'h0000_0300);
		tick(4);
		wreg(OFF_PIN_IRQ, 32'h0000_0FFF);
		wreg(OFF_TIME_IRQ, 32'h0000_01FF);
		@(posedge clk);
		ts <= 6'h3F;
		@(posedge clk);
		ts <= 6'h00;
		tick(3);
		check("time_sum_off", 64'h0, time_sum);
		rreg(OFF_TIME_IRQ, 32'h0000_003F);
		wreg(OFF_TIME_IRQ, 32'h01FF_0000);
		tick(2);
		check("time_sum", 64'h1, time_sum);
		wreg(OFF_TIME_IRQ, 32'h01FF_003F);
		wreg(OFF_BUF_CFG, 32'h0001_0000);
		// Captures on both time pins; only pin 8 may clear the target.
		for (int k = 0; k < 2; k++) begin
			@(posedge clk);
			hit <= 1'b1;
			tnow <= {32'($random(seed)), 32'($random(seed))};
			@(posedge clk);
			hit <= 1'b0;
			ext_val[8+k] <= 1'b1;
			@(posedge clk);
			ext_val[8+k] <= 1'b0;
			tick(4);
			rreg(OFF_TIME_IRQ, k ? 32'h01FF_0140 : 32'h01FF_0100);
			@(posedge clk);
			ext_val[8+k] <= 1'b1;
			tick(8);
			rreg(8'(OFF_CAP8_HI + 8 * k), tnow[63:32]);
			rreg(8'(OFF_CAP8_LO + 8 * k), tnow[31:0]);
			rreg(OFF_TIME_IRQ, k ? 32'h01FF_01C0 : 32'h01FF_0040);
			rreg(OFF_PIN_IRQ, k ? 32'h0000_0300 : 32'h0000_0100);
			@(posedge clk);
			ext_val[8+k] <= 1'b0;
		end
		// Event outputs: pin 8 active high, pin 9 active low.
		@(posedge clk);
		ext_en <= 12'hCFF;
		wreg(OFF_BUF_CFG, 32'h0000_7000);
		for (int m = 0; m < 4; m++) begin
			wreg(OFF_EVT_MODE, {28'h0, 2'(m), 2'(m)});
			// Follow mode starts from a cleared target flag.
			if (m == 3)
				wreg(OFF_TIME_IRQ, 32'h01FF_0100);
			tick(3);
			check("ev_oe", 64'h3, pin_oe[9:8]);
			pre8 = pin_out[8];
			pre9 = pin_out[9];
			if (m == 3)
				check("ev8_pre", 64'h0, pre8);
			@(posedge clk);
			hit <= 1'b1;
			@(posedge clk);
			hit <= 1'b0;
			cnt = 0;
			repeat (6) begin
				tick(1);
				if (pin_out[8] === 1'b1)
					cnt++;
			end
			if (m == 1)
				check("pulse_len", 64'(PULSE_CYC), 64'(cnt));
			check("ev8", (m == 2) ? !pre8 : (m == 3), pin_out[8]);
			check("ev9", (m == 2) ? !pre9 : (m != 3), pin_out[9]);
		end
		// A write while the clock enable is low must be ignored.
		@(posedge clk);
		ce <= 1'b0;
		wreg(OFF_IRQ_POL, 32'h0000_0FFF);
		@(posedge clk);
		ce <= 1'b1;
		rreg(OFF_IRQ_POL, 32'h0000_0300);
		wreg(8'hFC, 32'hFFFF_FFFF);
		rreg(8'hFC, 32'h0000_0000);
		tick(3);
		check("queue", 64'h0, 64'(expq.size()));
		end_sim();
	end
endmodule // gpp_ctrl_test
